// >>> operand_addressing_modes.sv
// Operand fetch and effective-address generator for one instruction.
// Expects the instruction word stream already fetched and register values
// already read by the core; one request handled per accepted start.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// [RL1] Short immediate is 16-bit signed, sign-extended to 32 bits.
// [RL2] Long immediate is 32-bit signed, from two extension words.
// [RL3] Constant is 5 bits inside the opcode, no extension word.
// [RL4] Immediate source always pairs with register-direct destination.
// [RL5] Register-direct pair shares one file except the plain move.
// [RL6] Absolute mode takes a 32-bit address from following words; a destination after source words gets the second word twice.
// [RL7] Register-indirect uses register contents unchanged as address.
// [RL8] Offset mode adds signed offset; register left unchanged.
// [RL9] Postincrement uses current value, then adds field size; a source is not written back when the destination also is.
// [RL10] Predecrement subtracts field size first, uses and keeps result; a source does not keep it when the destination also writes back.
// [RL11] Register-to-memory field move writes only low field-size bits.
// [RL12] XY-indirect register is an XY address; pixel from source low end.
// [RL13] Program counter advances past all extension words.
// [RL14] Exactly eight addressing modes are decoded.
// [RL15] XY register holds signed Y in upper half, signed X lower half.
// [RL16] Address arithmetic wraps modulo two to the 32nd, no trap.
module operand_addressing_modes #(
  parameter int ADDR_WIDTH = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  input  wire logic                 start,
  input  wire opmode_pkg::op_req_t  req,
  input  wire logic [31:0]          pc,
  input  wire logic [15:0]          extWord0,
  input  wire logic [15:0]          extWord1,
  input  wire logic [31:0]          srcRegValue,
  input  wire logic [31:0]          dstRegValue,
  output logic                      done,
  output opmode_pkg::op_res_t       res
);
  import opmode_pkg::*;

  op_res_t res_q;
  op_res_t res_d;
  logic    done_q;
  logic    done_d;

  // Masks a register value to its lowest fieldSize bits; 0 stands for 32
  function automatic logic [31:0] fieldMask(input logic [31:0] v, input logic [5:0] fs);
    logic [31:0] m;
    m = (fs == 6'h00 || fs >= 6'h20) ? 32'hFFFF_FFFF : ((32'h0000_0001 << fs) - 32'h0000_0001);
    return v & m;
  endfunction

  function automatic logic [31:0] fsExt(input logic [5:0] fs);
    return (fs == 6'h00) ? 32'h0000_0020 : {26'h0, fs};
  endfunction

  // Extension words a mode consumes, in 16-bit units
  function automatic logic [1:0] extWords(input addr_mode_t m, input imm_kind_t k);
    logic [1:0] n;
    n = 2'h0;
    unique case (m) // RL14
      AM_IMM:  n = (k == IMM_LONG) ? 2'h2 : ((k == IMM_SHORT) ? 2'h1 : 2'h0);
      AM_ABS:  n = 2'h2;
      AM_OFS:  n = 2'h1;
      AM_REG, AM_IND, AM_POSTINC, AM_PREDEC, AM_XY: n = 2'h0;
    endcase
    return n;
  endfunction

  // Effective address of one memory operand; immediate and register give zero
  function automatic logic [31:0] effAddr(input addr_mode_t m, input logic [31:0] r,
                                          input logic [31:0] absA, input logic [31:0] ofs,
                                          input logic [31:0] fs);
    logic [31:0] a;
    a = r;
    unique case (m)
      AM_ABS:     a = absA; // RL6
      AM_IND:     a = r; // RL7
      AM_OFS:     a = r + ofs; // RL8 RL16
      AM_POSTINC: a = r; // RL9
      AM_PREDEC:  a = r - fs; // RL10 RL16
      AM_XY:      a = r; // RL12
      AM_IMM, AM_REG: a = ZERO32;
    endcase
    return a;
  endfunction

  logic [31:0] absAddr;
  logic [31:0] srcOfs32;
  logic [31:0] dstOfs32;
  logic [31:0] fsz;
  logic [2:0]  srcWords;
  logic [2:0]  dstWords;
  logic [15:0] dstExt0;
  logic [15:0] dstExt1;

  always_comb
  begin
    res_d   = res_q;
    done_d  = 1'b0;
    fsz     = fsExt(req.fieldSize);
    srcWords = {1'b0, extWords(req.srcMode, req.immKind)};
    dstWords = {1'b0, extWords(req.dstMode, req.immKind)};
    // Source extension words come first; destination words follow them
    absAddr = (req.srcMode == AM_ABS) ? {extWord1, extWord0} : ZERO32; // RL6
    dstExt0 = (srcWords == 3'h0) ? extWord0 : extWord1;
    // Only two words arrive, so an absolute destination after a source word is cut short
    dstExt1 = extWord1;
    // A source offset owns the first word; a destination offset takes the next one
    srcOfs32 = {{16{extWord0[15]}}, extWord0}; // RL8
    dstOfs32 = {{16{dstExt0[15]}}, dstExt0}; // RL8
    if (start)
    begin
      done_d          = 1'b1;
      res_d.illegal   = 1'b0;
      res_d.regWriteback = 1'b0;
      res_d.wbReg     = req.srcReg;
      res_d.wbFile    = req.srcFile;
      res_d.wbValue   = ZERO32;
      res_d.xCoord    = 16'h0000;
      res_d.yCoord    = 16'h0000;
      res_d.writeData = srcRegValue;
      // Source operand
      if (req.srcMode == AM_IMM)
      begin
        unique case (req.immKind)
          IMM_SHORT: res_d.srcValue = {{16{extWord0[15]}}, extWord0}; // RL1
          IMM_LONG:  res_d.srcValue = {extWord1, extWord0}; // RL2
          default:   res_d.srcValue = {27'h0, req.konst}; // RL3
        endcase
        if (req.dstMode != AM_REG)
          res_d.illegal = 1'b1; // RL4
      end
      else
      begin
        res_d.srcValue = srcRegValue;
      end
      if (req.srcMode == AM_REG && req.dstMode == AM_REG &&
          req.srcFile != req.dstFile && !req.isPlainMove)
        res_d.illegal = 1'b1; // RL5
      res_d.srcAddr = effAddr(req.srcMode, srcRegValue, absAddr, srcOfs32, fsz);
      res_d.dstAddr = effAddr(req.dstMode, dstRegValue,
                              (req.dstMode == AM_ABS) ? {dstExt1, dstExt0} : ZERO32,
                              dstOfs32, fsz);
      // Register source to memory, other than a pixel op, writes only the low field bits
      if (req.srcMode == AM_REG && req.dstMode != AM_REG && !req.pixelOp)
        res_d.writeData = fieldMask(srcRegValue, req.fieldSize); // RL11
      if (req.dstMode == AM_XY)
      begin
        res_d.yCoord = dstRegValue[31:16]; // RL15
        res_d.xCoord = dstRegValue[15:0]; // RL15
      end
      else if (req.srcMode == AM_XY)
      begin
        res_d.yCoord = srcRegValue[31:16];
        res_d.xCoord = srcRegValue[15:0];
      end
      // Postincrement/predecrement write back; destination wins if both
      if (req.srcMode == AM_POSTINC || req.srcMode == AM_PREDEC)
      begin
        res_d.regWriteback = 1'b1;
        res_d.wbReg  = req.srcReg;
        res_d.wbFile = req.srcFile;
        res_d.wbValue = (req.srcMode == AM_POSTINC) ? srcRegValue + fsz // RL9 RL16
                                                    : srcRegValue - fsz; // RL10
      end
      if (req.dstMode == AM_POSTINC || req.dstMode == AM_PREDEC)
      begin
        res_d.regWriteback = 1'b1;
        res_d.wbReg  = req.dstReg;
        res_d.wbFile = req.dstFile;
        res_d.wbValue = (req.dstMode == AM_POSTINC) ? dstRegValue + fsz // RL9 RL16
                                                    : dstRegValue - fsz; // RL10
      end
      // Opcode word plus all extension words, in bits
      res_d.nextPc = pc + WORD_STEP + WORD_STEP * {29'h0, srcWords + dstWords}; // RL13
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      res_q  <= '0;
      done_q <= 1'b0;
    end
    else if (clkEn)
    begin
      res_q  <= res_d;
      done_q <= done_d;
    end
  end

  assign done = done_q;
  assign res  = res_q;

  chk_short_sign: assert property (@(posedge clk) disable iff (rst) // RL1
    clkEn && start && req.srcMode == AM_IMM && req.immKind == IMM_SHORT
    |=> res.srcValue == {{16{$past(extWord0[15])}}, $past(extWord0)})
    else $error("short immediate not sign extended");
  chk_long_imm: assert property (@(posedge clk) disable iff (rst) // RL2
    clkEn && start && req.srcMode == AM_IMM && req.immKind == IMM_LONG
    |=> res.srcValue == {$past(extWord1), $past(extWord0)} && done)
    else $error("long immediate wrong");
  chk_imm_dest: assert property (@(posedge clk) disable iff (rst) // RL4
    clkEn && start && req.srcMode == AM_IMM && req.dstMode != AM_REG |=> res.illegal)
    else $error("immediate to memory not flagged");
  chk_offset_add: assert property (@(posedge clk) disable iff (rst) // RL8
    clkEn && start && req.srcMode == AM_REG && req.dstMode == AM_OFS
    |=> res.dstAddr == $past(dstRegValue) + {{16{$past(extWord0[15])}}, $past(extWord0)}
        && !res.regWriteback)
    else $error("offset address wrong");
  chk_postinc_wb: assert property (@(posedge clk) disable iff (rst) // RL9
    clkEn && start && req.dstMode == AM_POSTINC
    |=> res.dstAddr == $past(dstRegValue) && res.wbValue == res.dstAddr + $past(fsz))
    else $error("postincrement wrong");
  chk_predec_addr: assert property (@(posedge clk) disable iff (rst) // RL10
    clkEn && start && req.dstMode == AM_PREDEC
    |=> res.dstAddr == res.wbValue && res.wbValue == $past(dstRegValue) - $past(fsz))
    else $error("predecrement wrong");
  chk_xy_split: assert property (@(posedge clk) disable iff (rst) // RL15
    clkEn && start && req.dstMode == AM_XY
    |=> {res.yCoord, res.xCoord} == $past(dstRegValue))
    else $error("xy halves wrong");
  chk_pc_advance: assert property (@(posedge clk) disable iff (rst) // RL13
    clkEn && start && req.srcMode == AM_ABS && req.dstMode == AM_REG
    |=> res.nextPc == $past(pc) + 32'h0000_0030)
    else $error("pc not past extension words");
  chk_field_write: assert property (@(posedge clk) disable iff (rst) // RL11
    clkEn && start && req.srcMode == AM_REG && req.dstMode == AM_IND && !req.pixelOp
    && req.fieldSize == 6'h10 |=> res.writeData[31:16] == 16'h0000)
    else $error("field write not masked");
  // Corners that the random mix reaches rarely get checks of their own
  chk_const_imm: assert property (@(posedge clk) disable iff (rst) // RL3
    clkEn && start && req.srcMode == AM_IMM && req.immKind == IMM_CONST
    && req.dstMode == AM_REG
    |=> res.srcValue == {27'h0, $past(req.konst)} && res.nextPc == $past(pc) + WORD_STEP)
    else $error("constant operand wrong");
  chk_short_pc: assert property (@(posedge clk) disable iff (rst) // RL13
    clkEn && start && req.srcMode == AM_IMM && req.immKind == IMM_SHORT
    && req.dstMode == AM_REG |=> res.nextPc == $past(pc) + WORD_STEP + WORD_STEP)
    else $error("pc not past short immediate");
  chk_cross_file: assert property (@(posedge clk) disable iff (rst) // RL5
    clkEn && start && req.srcMode == AM_REG && req.dstMode == AM_REG
    && req.srcFile != req.dstFile && !req.isPlainMove |=> res.illegal)
    else $error("cross-file register pair not flagged");
  chk_reg_pair: assert property (@(posedge clk) disable iff (rst) // RL5
    clkEn && start && req.srcMode == AM_REG && req.dstMode == AM_REG
    && req.srcFile == req.dstFile
    |=> !res.illegal && !res.regWriteback && res.nextPc == $past(pc) + WORD_STEP)
    else $error("same-file register pair wrong");
  chk_abs_src: assert property (@(posedge clk) disable iff (rst) // RL6
    clkEn && start && req.srcMode == AM_ABS
    |=> res.srcAddr == {$past(extWord1), $past(extWord0)})
    else $error("absolute source address wrong");
  chk_ind_addr: assert property (@(posedge clk) disable iff (rst) // RL7
    clkEn && start && req.srcMode == AM_REG && req.dstMode == AM_IND
    |=> res.dstAddr == $past(dstRegValue) && !res.regWriteback)
    else $error("indirect address not the register");
  chk_two_offsets: assert property (@(posedge clk) disable iff (rst) // RL8
    clkEn && start && req.srcMode == AM_OFS && req.dstMode == AM_OFS
    |=> res.srcAddr == $past(srcRegValue) + {{16{$past(extWord0[15])}}, $past(extWord0)}
        && res.dstAddr == $past(dstRegValue) + {{16{$past(extWord1[15])}}, $past(extWord1)})
    else $error("offset words not paired to operands");
  chk_dest_wins: assert property (@(posedge clk) disable iff (rst) // RL9
    clkEn && start && req.srcMode == AM_POSTINC && req.dstMode == AM_POSTINC
    |=> res.regWriteback && res.wbReg == $past(req.dstReg) && res.wbFile == $past(req.dstFile)
        && res.wbValue == $past(dstRegValue) + $past(fsz))
    else $error("destination writeback did not win");
  chk_src_predec: assert property (@(posedge clk) disable iff (rst) // RL16
    clkEn && start && req.srcMode == AM_PREDEC && req.dstMode == AM_REG
    |=> res.srcAddr == $past(srcRegValue) - $past(fsz) && res.wbValue == res.srcAddr
        && res.regWriteback)
    else $error("source predecrement wrong");
  chk_pixel_low: assert property (@(posedge clk) disable iff (rst) // RL12
    clkEn && start && req.pixelOp && req.srcMode == AM_REG && req.dstMode == AM_XY
    |=> res.writeData == $past(srcRegValue) && res.dstAddr == $past(dstRegValue))
    else $error("pixel transfer data or address wrong");
  chk_xy_src: assert property (@(posedge clk) disable iff (rst) // RL15
    clkEn && start && req.srcMode == AM_XY && req.dstMode != AM_XY
    |=> {res.yCoord, res.xCoord} == $past(srcRegValue))
    else $error("source xy halves wrong");
  chk_done_pulse: assert property (@(posedge clk) disable iff (rst) // RL14
    clkEn |=> done == $past(start))
    else $error("done does not follow start");
  chk_enable_hold: assert property (@(posedge clk) disable iff (rst) // RL13
    !clkEn |=> $stable(res) && $stable(done))
    else $error("state moved while enable low");

  // Scenarios the bench is expected to reach
  cov_postinc: cover property (@(posedge clk) disable iff (rst)
    clkEn && start && req.srcMode == AM_POSTINC && req.dstMode == AM_POSTINC);
  cov_long_imm: cover property (@(posedge clk) disable iff (rst)
    clkEn && start && req.immKind == IMM_LONG && req.srcMode == AM_IMM);
  cov_xy: cover property (@(posedge clk) disable iff (rst)
    clkEn && start && req.pixelOp && req.dstMode == AM_XY);
  cov_cross_move: cover property (@(posedge clk) disable iff (rst)
    clkEn && start && req.srcMode == AM_REG && req.dstMode == AM_REG
    && req.srcFile != req.dstFile && req.isPlainMove);
  cov_enable_hold: cover property (@(posedge clk) disable iff (rst)
    !clkEn && start);

endmodule

`default_nettype wire

// >>> opmode_pkg.sv
// Package for the operand addressing-mode decoder.
// Assumes a 16-bit instruction word stream and 32-bit bit addresses.
package opmode_pkg;

  localparam int WORD_W       = 16;
  localparam int ADDR_W       = 32;
  localparam int CONST_W      = 5;
  localparam int COORD_W      = 16;
  localparam int WORD_BITS    = 16;
  localparam logic [31:0] WORD_STEP = 32'h0000_0010;
  localparam logic [31:0] ZERO32    = 32'h0000_0000;

  // Eight operand addressing modes
  typedef enum logic [2:0] {
    AM_IMM, AM_ABS, AM_REG, AM_IND, AM_OFS, AM_POSTINC, AM_PREDEC, AM_XY
  } addr_mode_t;

  // Immediate kinds for immediate mode
  typedef enum logic [1:0] {
    IMM_CONST, IMM_SHORT, IMM_LONG
  } imm_kind_t;

  typedef struct packed {
    addr_mode_t  srcMode;
    addr_mode_t  dstMode;
    imm_kind_t   immKind;
    logic        srcFile;
    logic        dstFile;
    logic        isPlainMove;
    logic [3:0]  srcReg;
    logic [3:0]  dstReg;
    logic [4:0]  konst;
    logic [5:0]  fieldSize;
    logic        pixelOp;
  } op_req_t;

  typedef struct packed {
    logic [31:0] srcAddr;
    logic [31:0] dstAddr;
    logic [31:0] srcValue;
    logic [31:0] writeData;
    logic [15:0] xCoord;
    logic [15:0] yCoord;
    logic        regWriteback;
    logic [3:0]  wbReg;
    logic        wbFile;
    logic [31:0] wbValue;
    logic [31:0] nextPc;
    logic        illegal;
  } op_res_t;

endpackage

// >>> ext_word_memory.sv
// Behavioural program memory that hands out the words after an opcode.
// Assumes 16-bit words at bit addresses that are multiples of 16.
`timescale 1ns/1ps
`default_nettype none
module ext_word_memory (
  input  wire logic [31:0] pc,
  output logic      [15:0] extWord0,
  output logic      [15:0] extWord1
);
  logic [15:0] mem [0:255];

  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 16'hA5C3 ^ 16'(i * 16'h1F35);
    end
  end

  // Extension words follow the opcode, low word first
  assign extWord0 = mem[8'(pc[11:4] + 8'h01)];
  assign extWord1 = mem[8'(pc[11:4] + 8'h02)];
endmodule
`default_nettype wire

// >>> operand_addressing_modes_tb.sv
// Self-checking bench for the operand addressing-mode decoder.
// Assumes opmode_pkg and the extension word memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module operand_addressing_modes_tb;
  import opmode_pkg::*;
  logic        clk, rst, clkEn, start, done;
  op_req_t     req;
  op_res_t     res;
  logic [31:0] pc, srcRegValue, dstRegValue, keepPc;
  logic [15:0] extWord0, extWord1;
  int          numErrors, totalChecks;

  operand_addressing_modes dut (.clk(clk), .rst(rst), .clkEn(clkEn), .start(start), .req(req),
    .pc(pc), .extWord0(extWord0), .extWord1(extWord1), .srcRegValue(srcRegValue),
    .dstRegValue(dstRegValue), .done(done), .res(res));
  ext_word_memory mem (.pc(pc), .extWord0(extWord0), .extWord1(extWord1));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic int nwords(addr_mode_t m, imm_kind_t k);
    if (m == AM_IMM)
      return (k == IMM_LONG) ? 2 : (k == IMM_SHORT) ? 1 : 0;
    return (m == AM_ABS) ? 2 : (m == AM_OFS) ? 1 : 0;
  endfunction

  function automatic logic [31:0] eaddr(addr_mode_t m, logic [31:0] r, logic [31:0] f);
    case (m)
      AM_ABS:    return {extWord1, extWord0};
      AM_OFS:    return r + {{16{extWord0[15]}}, extWord0};
      AM_PREDEC: return r - f;
      AM_IMM, AM_REG: return 32'h0000_0000;
      default:   return r;
    endcase
  endfunction

  task automatic runOp(input addr_mode_t sm, input addr_mode_t dm, input imm_kind_t k,
                       input logic sf, input logic df, input logic plain, input int p);
    logic [31:0] f, r;
    addr_mode_t  am;
    logic        useDst;
    @(negedge clk);
    req = '0;
    req.srcMode = sm;
    req.dstMode = dm;
    req.immKind = k;
    req.srcFile = sf;
    req.dstFile = df;
    req.isPlainMove = plain;
    req.srcReg = 4'($urandom);
    req.dstReg = 4'($urandom);
    req.konst = 5'($urandom);
    req.fieldSize = (p == 0) ? 6'h10 : (p == 1) ? 6'h00 : 6'($urandom_range(32, 0));
    req.pixelOp = (dm == AM_XY);
    pc = {20'h0, 8'($urandom_range(200, 0)), 4'h0};
    // Small register values on the first pass make predecrement wrap
    srcRegValue = (p == 0) ? 32'h0000_0008 : $urandom;
    dstRegValue = (p == 0) ? 32'h0000_0008 : $urandom;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    f = (req.fieldSize == 6'h00) ? 32'h0000_0020 : {26'h0, req.fieldSize};
    check("done", 32'(done), 32'h1);
    check("nextPc", res.nextPc, pc + 32'(16 * (1 + nwords(sm, k) + nwords(dm, k))));
    check("illegal", 32'(res.illegal), 32'((sm == AM_IMM && dm != AM_REG) ||
          (sm == AM_REG && dm == AM_REG && sf != df && !plain)));
    if (sm == AM_IMM && dm == AM_REG)
      check("srcValue", res.srcValue, (k == IMM_LONG) ? {extWord1, extWord0} :
            (k == IMM_SHORT) ? {{16{extWord0[15]}}, extWord0} : {27'h0, req.konst});
    else if (sm != AM_REG && sm != AM_XY)
      check("srcAddr", res.srcAddr, eaddr(sm, srcRegValue, f));
    if (sm == AM_REG && dm != AM_REG && dm != AM_XY)
    begin
      check("dstAddr", res.dstAddr, eaddr(dm, dstRegValue, f));
      check("writeData", res.writeData, srcRegValue & 32'((64'h1 << f) - 1));
    end
    if (dm == AM_XY)
    begin
      check("xCoord", {16'h0, res.xCoord}, {16'h0, dstRegValue[15:0]});
      check("yCoord", {16'h0, res.yCoord}, {16'h0, dstRegValue[31:16]});
      check("xyAddr", res.dstAddr, dstRegValue);
      check("pixelData", res.writeData, srcRegValue);
    end
    else if (sm == AM_XY)
      check("srcXy", {res.yCoord, res.xCoord}, srcRegValue);
    if (sm == AM_OFS && dm == AM_OFS)
      check("dstOffset", res.dstAddr, dstRegValue + {{16{extWord1[15]}}, extWord1});
    // Destination writeback wins when both operands modify their register
    useDst = (dm == AM_POSTINC || dm == AM_PREDEC || sm == AM_REG);
    am = useDst ? dm : sm;
    r = useDst ? dstRegValue : srcRegValue;
    if (am == AM_POSTINC || am == AM_PREDEC)
    begin
      check("wbValue", res.wbValue, (am == AM_POSTINC) ? r + f : r - f);
      check("wbReg", {28'h0, res.wbReg}, {28'h0, useDst ? req.dstReg : req.srcReg});
      check("wbFile", 32'(res.wbFile), 32'(useDst ? df : sf));
    end
    if (am == AM_IND || am == AM_OFS || am == AM_POSTINC || am == AM_PREDEC)
      check("regWriteback", 32'(res.regWriteback), 32'(am != AM_IND && am != AM_OFS));
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    #(25 * 3000);
    numErrors++;
    conclude();
  end

  initial
  begin
    rst = 1'b1;
    clkEn = 1'b1;
    start = 1'b0;
    req = '0;
    pc = '0;
    srcRegValue = '0;
    dstRegValue = '0;
    numErrors = 0;
    totalChecks = 0;
    void'($urandom(37));
    repeat (6) @(negedge clk);
    check("resetDone", 32'(done), 32'h0);
    check("resetPc", res.nextPc, 32'h0);
    rst = 1'b0;
    for (int p = 0; p < 4; p++)
    begin
      for (int m = 0; m < 8; m++)
      begin
        runOp(addr_mode_t'(m), AM_REG, imm_kind_t'((m == 0) ? p % 3 : 0), 1'b0, 1'b0, 1'b0, p);
        if (m != 0)
          runOp(AM_REG, addr_mode_t'(m), IMM_CONST, 1'b1, 1'b1, 1'b0, p);
      end
      runOp(AM_IMM, addr_mode_t'(p + 1), imm_kind_t'(p % 3), 1'b0, 1'b0, 1'b0, p);
      runOp(AM_REG, AM_REG, IMM_CONST, 1'b0, 1'b1, 1'(p), p);
      runOp(AM_OFS, AM_OFS, IMM_CONST, 1'b1, 1'b1, 1'b0, p);
      runOp(AM_POSTINC, AM_POSTINC, IMM_CONST, 1'b0, 1'b1, 1'b0, p);
      $display("Pass %0d finished", p);
    end
    // Enable low must hold the pulse and the result, even with a request up
    keepPc = res.nextPc;
    clkEn = 1'b0;
    @(negedge clk);
    check("frozenDone", 32'(done), 32'h1);
    start = 1'b1;
    pc = pc + 32'h0000_0100;
    @(negedge clk);
    check("frozenPc", res.nextPc, keepPc);
    start = 1'b0;
    clkEn = 1'b1;
    @(negedge clk);
    check("doneCleared", 32'(done), 32'h0);
    // A reset in mid-run clears the result; the next request must still work
    rst = 1'b1;
    @(negedge clk);
    check("midResetPc", res.nextPc, 32'h0);
    rst = 1'b0;
    runOp(AM_ABS, AM_REG, IMM_CONST, 1'b0, 1'b0, 1'b0, 1);
    $display("Corner tests finished");
    conclude();
  end
endmodule
`default_nettype wire
